// [rtl/apc_pkg.sv]
// Constants and types for the audio PLL coefficient and clock-divider block
// Function
// - K is held as integer J plus four decimal fraction digits D.
// - A single enable bit, bit 0 of register 4, turns the PLL on.
// - P, J, D high, D low and R sit in registers 20 to 24.
// - Internal reference is the master clock divided by P.
// - Overall multiplication factor is K times R.
// - DSP clock is the VCO clock divided by the DSP divisor.
// - Modulator clock is the VCO clock divided by the modulator divisor.
// - Charge pump clock is the modulator clock divided by the pump divisor.
// - Sample rate mismatch can only arise when the device is clock master.
// - The PLL enable bit is set after reset.
// - VCO equals input times R times K over P, R from 1 to 16.
package apc_pkg;

    // ------------------------------------------------------------
    // Register map, page 0
    // ------------------------------------------------------------
    localparam logic [7:0] PAGE_CFG = 8'h00;
    localparam logic [7:0] OFS_PLL_CONTROL = 8'h04;
    localparam logic [7:0] OFS_PRE_DIVIDER = 8'h14;
    localparam logic [7:0] OFS_INT_MULT = 8'h15;
    localparam logic [7:0] OFS_FRAC_HIGH = 8'h16;
    localparam logic [7:0] OFS_FRAC_LOW = 8'h17;
    localparam logic [7:0] OFS_POST_MULT = 8'h18;

    // Field positions
    localparam int PLL_ON_BIT = 0;
    localparam int PRE_DIV_W = 4;
    localparam int INT_MULT_W = 6;
    localparam int FRAC_HIGH_W = 6;
    localparam int FRAC_W = 14;
    localparam int POST_MULT_W = 4;

    // Values after reset
    localparam logic RST_PLL_ON = 1'b1;
    localparam logic [3:0] RST_PRE_DIV = 4'h0;
    localparam logic [5:0] RST_INT_MULT = 6'h08;
    localparam logic [13:0] RST_FRAC = 14'h0000;
    localparam logic [3:0] RST_POST_MULT = 4'h0;

    // ------------------------------------------------------------
    // Range limits, frequencies in kHz, fraction scale 10000
    // ------------------------------------------------------------
    localparam logic [47:0] FRAC_SCALE = 48'h0000_0000_2710;   // 10000
    localparam logic [13:0] FRAC_MAX = 14'h270f;               // 9999
    localparam logic [47:0] REF_MIN_INT_KHZ = 48'h0000_0000_03e8;   // 1 MHz
    localparam logic [47:0] REF_MIN_FRAC_KHZ = 48'h0000_0000_1a0b;  // 6.667 MHz
    localparam logic [47:0] REF_MAX_KHZ = 48'h0000_0000_4e20;       // 20 MHz
    localparam logic [47:0] VCO_MIN_KHZ = 48'h0000_0000_fa00;       // 64 MHz
    localparam logic [47:0] VCO_MAX_KHZ = 48'h0000_0001_86a0;       // 100 MHz
    localparam logic [5:0] J_MIN_INT = 6'h01;
    localparam logic [5:0] J_MAX_INT = 6'h3f;
    localparam logic [5:0] J_MIN_FRAC = 6'h04;
    localparam logic [5:0] J_MAX_FRAC = 6'h0b;
    localparam logic [11:0] VCO_PER_SAMPLE = 12'h800;              // 2048

    // Coefficient set as held in the registers
    typedef struct packed {
        logic [3:0] p;      // Pre-divider, value is field plus one
        logic [5:0] j;      // Integer multiplier
        logic [13:0] d;     // Four decimal fraction digits
        logic [3:0] r;      // Post multiplier, value is field plus one
    } apc_coef_t;

    // Divisor fields for the derived clocks, each value is field plus one
    typedef struct packed {
        logic [6:0] dsp;
        logic [6:0] modulator;
        logic [6:0] oversample;
        logic [6:0] pump;
    } apc_divs_t;

endpackage

// [rtl/apc_clk_div.sv]
// Enable-pulse divider: one output pulse per (divisor field + 1) source pulses
`timescale 1ns/1ns
module apc_clk_div #(
    parameter int W = 7
) (
    input wire logic i_clk,           // System clock
    input wire logic i_rst,           // Async reset, active high
    input wire logic i_src,           // Source enable pulse
    input wire logic [W-1:0] i_div,   // Divisor minus one
    output logic o_tick               // Divided enable pulse
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_tick;

    // Count source pulses; wrap on reaching the field so a shrinking divisor never hangs
    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (i_src) begin
            if (cnt >= i_div) begin
                next_cnt = '0;
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    // Register stage
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule

// [rtl/apc_pll_cfg.sv]
// Audio PLL coefficient registers, range checker and derived clock enables
`timescale 1ns/1ns
module apc_pll_cfg (
    input wire logic i_clk,                 // Master clock, 100 MHz
    input wire logic i_rst,                 // Async reset, active high
    input wire logic [7:0] i_page,          // Currently selected register page
    input wire logic i_wr,                  // Register write strobe
    input wire logic i_rd,                  // Register read strobe
    input wire logic [7:0] i_addr,          // Register offset
    input wire logic [7:0] i_wdata,         // Write data
    input wire logic [15:0] i_ref_khz,      // Measured reference clock in kHz
    input wire logic i_vco_tick,            // One pulse per VCO cycle from the PLL
    input wire logic i_clk_master,          // Device drives the audio clocks
    input wire apc_pkg::apc_divs_t i_divs,  // Derived clock divisors
    output logic [7:0] o_rdata,             // Read data
    output logic o_pll_en,                  // PLL enable to the analog core
    output apc_pkg::apc_coef_t o_coef,      // Coefficients to the analog core
    output logic [23:0] o_mult_x10k,        // K times R, scaled by 10000
    output logic o_cfg_err,                 // Coefficients outside the legal range
    output logic o_rate_mismatch,           // Sample rate may drift from target
    output logic o_ref_en,                  // Reference enable, master clock over P
    output logic o_dsp_en,                  // DSP core clock enable
    output logic o_mod_en,                  // Modulator clock enable
    output logic o_osr_en,                  // Oversample clock enable
    output logic o_pump_en                  // Charge pump clock enable
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic pll_on;
    apc_pkg::apc_coef_t coef;
    logic next_pll_on;
    apc_pkg::apc_coef_t next_coef;
    logic [7:0] next_rdata;
    logic sel;

    // Writes land only on the configuration page
    always_comb begin
        sel = (i_page == apc_pkg::PAGE_CFG);
        next_pll_on = pll_on;
        next_coef = coef;
        if (i_wr && sel) begin
            case (i_addr)
                apc_pkg::OFS_PLL_CONTROL: next_pll_on = i_wdata[apc_pkg::PLL_ON_BIT];
                apc_pkg::OFS_PRE_DIVIDER: next_coef.p = i_wdata[3:0];
                apc_pkg::OFS_INT_MULT: next_coef.j = i_wdata[5:0];
                apc_pkg::OFS_FRAC_HIGH: next_coef.d[13:8] = i_wdata[5:0];
                apc_pkg::OFS_FRAC_LOW: next_coef.d[7:0] = i_wdata;
                apc_pkg::OFS_POST_MULT: next_coef.r = i_wdata[3:0];
                default: next_pll_on = pll_on;
            endcase
        end
    end

    // Read mux; unused bits and unmapped offsets read zero
    always_comb begin
        next_rdata = o_rdata;
        if (i_rd) begin
            next_rdata = 8'h00;
            if (sel) begin
                case (i_addr)
                    apc_pkg::OFS_PLL_CONTROL: next_rdata = {7'h00, pll_on};
                    apc_pkg::OFS_PRE_DIVIDER: next_rdata = {4'h0, coef.p};
                    apc_pkg::OFS_INT_MULT: next_rdata = {2'h0, coef.j};
                    apc_pkg::OFS_FRAC_HIGH: next_rdata = {2'h0, coef.d[13:8]};
                    apc_pkg::OFS_FRAC_LOW: next_rdata = coef.d[7:0];
                    apc_pkg::OFS_POST_MULT: next_rdata = {4'h0, coef.r};
                    default: next_rdata = 8'h00;
                endcase
            end
        end
    end

    // Register file state; the PLL comes up running
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pll_on <= apc_pkg::RST_PLL_ON;
            coef <= {apc_pkg::RST_PRE_DIV, apc_pkg::RST_INT_MULT,
                     apc_pkg::RST_FRAC, apc_pkg::RST_POST_MULT};
            o_rdata <= 8'h00;
        end else begin
            pll_on <= next_pll_on;
            coef <= next_coef;
            o_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Range checker
    // ------------------------------------------------------------
    logic [47:0] p_val;
    logic [47:0] r_val;
    logic [47:0] k_x10k;
    logic [47:0] kr_x10k;
    logic [47:0] vco_num;
    logic frac_mode;
    logic ref_bad;
    logic vco_bad;
    logic mult_bad;
    logic next_cfg_err;
    logic next_mismatch;

    // Compare without dividing: ref/P against limits becomes ref against limit*P
    always_comb begin
        p_val = {44'h0, coef.p} + 48'h1;
        r_val = {44'h0, coef.r} + 48'h1;
        k_x10k = {42'h0, coef.j} * apc_pkg::FRAC_SCALE + {34'h0, coef.d};
        kr_x10k = k_x10k * r_val;
        vco_num = {32'h0, i_ref_khz} * kr_x10k;
        frac_mode = (coef.d != 14'h0000);
        ref_bad = ({32'h0, i_ref_khz} > apc_pkg::REF_MAX_KHZ * p_val);
        if (frac_mode) begin
            ref_bad = ref_bad || ({32'h0, i_ref_khz} < apc_pkg::REF_MIN_FRAC_KHZ * p_val);
            mult_bad = (coef.j < apc_pkg::J_MIN_FRAC) || (coef.j > apc_pkg::J_MAX_FRAC)
                || (coef.r != 4'h0) || (coef.d > apc_pkg::FRAC_MAX);
        end else begin
            ref_bad = ref_bad || ({32'h0, i_ref_khz} < apc_pkg::REF_MIN_INT_KHZ * p_val);
            mult_bad = (coef.j < apc_pkg::J_MIN_INT) || (coef.j > apc_pkg::J_MAX_INT);
        end
        vco_bad = (vco_num < apc_pkg::VCO_MIN_KHZ * apc_pkg::FRAC_SCALE * p_val)
            || (vco_num > apc_pkg::VCO_MAX_KHZ * apc_pkg::FRAC_SCALE * p_val);
        next_cfg_err = pll_on && (ref_bad || vco_bad || mult_bad);
        // A fractional K may not land on an exact VCO/2048 rate, and only a master sees it
        next_mismatch = pll_on && i_clk_master && frac_mode;
    end

    // Status and coefficient outputs, all registered
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pll_en <= 1'b0;
            o_coef <= '0;
            o_mult_x10k <= 24'h000000;
            o_cfg_err <= 1'b0;
            o_rate_mismatch <= 1'b0;
        end else begin
            o_pll_en <= pll_on;
            o_coef <= coef;
            o_mult_x10k <= kr_x10k[23:0];
            o_cfg_err <= next_cfg_err;
            o_rate_mismatch <= next_mismatch;
        end
    end

    // ------------------------------------------------------------
    // Clock tree enables
    // ------------------------------------------------------------
    logic vco_src;

    // Bypassed PLL runs the tree straight from the master clock
    assign vco_src = pll_on ? i_vco_tick : 1'b1;

    // Reference: master clock over P
    apc_clk_div #(.W(4)) u_ref_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_src(1'b1),
        .i_div(coef.p),
        .o_tick(o_ref_en)
    );

    // DSP clock: VCO over the DSP divisor
    apc_clk_div #(.W(7)) u_dsp_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_src(vco_src),
        .i_div(i_divs.dsp),
        .o_tick(o_dsp_en)
    );

    // Modulator clock: VCO over the modulator divisor
    apc_clk_div #(.W(7)) u_mod_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_src(vco_src),
        .i_div(i_divs.modulator),
        .o_tick(o_mod_en)
    );

    // Oversample clock: modulator clock over the oversample divisor
    apc_clk_div #(.W(7)) u_osr_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_src(o_mod_en),
        .i_div(i_divs.oversample),
        .o_tick(o_osr_en)
    );

    // Charge pump clock: modulator clock over the pump divisor
    apc_clk_div #(.W(7)) u_pump_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_src(o_mod_en),
        .i_div(i_divs.pump),
        .o_tick(o_pump_en)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_ctl_write;
        i_wr && sel && (i_addr == apc_pkg::OFS_PLL_CONTROL);
    endsequence

    chk_pll_on_reset: assert property ($past(i_rst) |-> pll_on)
        else $error("PLL enable not set after reset");
    chk_pll_bit_write: assert property (
        s_ctl_write |=> ##1 (o_pll_en == $past(i_wdata[0], 2)))
        else $error("PLL enable bit did not follow write");
    chk_pre_div_write: assert property (
        (i_wr && sel && i_addr == apc_pkg::OFS_PRE_DIVIDER) |=> ##1
        (o_coef.p == $past(i_wdata[3:0], 2)))
        else $error("Pre-divider field not written");
    chk_ref_half_rate: assert property (
        (o_ref_en && coef.p == 4'h1) ##1 (coef.p == 4'h1) |-> !o_ref_en ##1 o_ref_en)
        else $error("Reference enable not master clock over two");
    chk_mult_product: assert property (
        o_mult_x10k == 24'((24'(o_coef.j) * 24'h002710 + 24'(o_coef.d))
            * (24'(o_coef.r) + 24'h000001)))
        else $error("Multiplication factor wrong");
    chk_frac_r_err: assert property (
        (pll_on && coef.d != 14'h0 && coef.r != 4'h0) |=> o_cfg_err)
        else $error("Fractional mode with R above one not flagged");
    chk_j_zero_err: assert property (
        (pll_on && coef.j == 6'h00) |=> o_cfg_err)
        else $error("Zero integer multiplier not flagged");
    chk_mismatch_master: assert property (
        o_rate_mismatch |-> $past(i_clk_master) && $past(coef.d) != 14'h0)
        else $error("Mismatch reported outside master fractional mode");
    chk_dsp_bypass: assert property (
        (!pll_on && i_divs.dsp == 7'h00) [*2] |-> o_dsp_en)
        else $error("Bypassed DSP enable not every cycle");
    chk_osr_from_mod: assert property (o_osr_en |-> $past(o_mod_en))
        else $error("Oversample enable without modulator enable");
    chk_pump_from_mod: assert property (o_pump_en |-> $past(o_mod_en))
        else $error("Pump enable without modulator enable");
    chk_mod_bypass: assert property (
        (!pll_on && i_divs.modulator == 7'h01) ##1 (!pll_on && i_divs.modulator == 7'h01)
        |-> ##1 (o_mod_en != $past(o_mod_en)))
        else $error("Bypassed modulator enable not halving");

endmodule

// [sim/apc_mclk_src.sv]
// Behavioural master clock source feeding the PLL reference and VCO ticks
`timescale 1ns/1ns
module apc_mclk_src (
    input wire logic i_clk,          // Bench clock
    input wire logic i_rst,          // Async reset, active high
    input wire logic [15:0] i_khz,   // Rate the source is asked to run at
    input wire logic i_slow,         // Tick every fourth clock, not every second
    output logic [15:0] o_ref_khz,   // Reported reference rate in kHz
    output logic o_vco_tick          // One pulse per modelled VCO cycle
);
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic next_tick;
    // ------------------------------------------------------------
    // Tick spacing
    // ------------------------------------------------------------
    // Slow mode stretches the spacing so the divider chain sees a lazy source
    always_comb begin
        next_phase = phase + 2'h1;
        if (!i_slow && phase == 2'h1) begin
            next_phase = 2'h0;
        end
        next_tick = (phase == 2'h0);
    end
    // Reference rate follows the ratio times sample rate the bench picked
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            phase <= 2'h0;
            o_vco_tick <= 1'b0;
            o_ref_khz <= 16'h0000;
        end else begin
            phase <= next_phase;
            o_vco_tick <= next_tick;
            o_ref_khz <= i_khz;
        end
    end
endmodule

// [sim/audio_pll_clock_config_tb.sv]
// Self-checking bench for the PLL coefficient registers and clock enables
`timescale 1ns/1ns
module audio_pll_clock_config_tb;
    logic i_clk, i_rst, wr, rd, master, slow, vco_tick;
    logic [7:0] page, addr, wdata, rdata;
    logic [15:0] set_khz, ref_khz;
    apc_pkg::apc_divs_t divs;
    apc_pkg::apc_coef_t coef;
    logic pll_en, cfg_err, mismatch, ref_en, dsp_en, mod_en, osr_en, pump_en;
    logic [23:0] mult;
    int n_errors = 0;
    int cmp_count = 0;
    logic [7:0] ofs [7] = '{8'h04, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h03};
    logic [7:0] rstv [7] = '{8'h01, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] fullv [7] = '{8'h01, 8'h0f, 8'h3f, 8'h3f, 8'hff, 8'h0f, 8'h00};

    apc_mclk_src src (.i_clk(i_clk), .i_rst(i_rst), .i_khz(set_khz), .i_slow(slow),
        .o_ref_khz(ref_khz), .o_vco_tick(vco_tick));
    apc_pll_cfg DUT (.i_clk(i_clk), .i_rst(i_rst), .i_page(page), .i_wr(wr), .i_rd(rd),
        .i_addr(addr), .i_wdata(wdata), .i_ref_khz(ref_khz), .i_vco_tick(vco_tick),
        .i_clk_master(master), .i_divs(divs), .o_rdata(rdata), .o_pll_en(pll_en),
        .o_coef(coef), .o_mult_x10k(mult), .o_cfg_err(cfg_err),
        .o_rate_mismatch(mismatch), .o_ref_en(ref_en), .o_dsp_en(dsp_en),
        .o_mod_en(mod_en), .o_osr_en(osr_en), .o_pump_en(pump_en));

    // ------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // A hang counts as a mismatch rather than a silent stall
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Access tasks and comparisons
    // ------------------------------------------------------------
    task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    // Strobes rise and fall on falling edges so the rising edge sees them settled
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge i_clk);
        wr = 1'b0;
    endtask
    task automatic exp_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        rd = 1'b1;
        addr = a;
        @(negedge i_clk);
        rd = 1'b0;
        chk_val("rdata", {24'h0, e}, {24'h0, rdata});
    endtask
    task automatic settle;
        repeat (3) @(negedge i_clk);
    endtask
    // Program one coefficient set and check the range flag and the product
    task automatic run_case(input logic [15:0] khz, input logic [3:0] p,
        input logic [5:0] j, input logic [7:0] dl, input logic [3:0] r, input logic e);
        logic [23:0] m;
        m = (24'(j) * 24'd10000 + 24'(dl)) * (24'(r) + 24'd1);
        set_khz = khz;
        wr_reg(8'h14, {4'h0, p});
        wr_reg(8'h15, {2'h0, j});
        wr_reg(8'h16, 8'h00);
        wr_reg(8'h17, dl);
        wr_reg(8'h18, {4'h0, r});
        settle();
        chk_val("cfg_err", {31'h0, e}, {31'h0, cfg_err});
        chk_val("mult", {8'h0, m}, {8'h0, mult});
    endtask
    // Pulse counts over a window that is a whole number of every period
    task automatic count_en(input int cyc, input int er, input int ed, input int em,
        input int eo, input int ep);
        int c [5];
        c = '{0, 0, 0, 0, 0};
        repeat (40) @(negedge i_clk);
        repeat (cyc) begin
            @(negedge i_clk);
            c[0] += int'(ref_en === 1'b1);
            c[1] += int'(dsp_en === 1'b1);
            c[2] += int'(mod_en === 1'b1);
            c[3] += int'(osr_en === 1'b1);
            c[4] += int'(pump_en === 1'b1);
        end
        chk_val("ref_en", er, c[0]);
        chk_val("dsp_en", ed, c[1]);
        chk_val("mod_en", em, c[2]);
        chk_val("osr_en", eo, c[3]);
        chk_val("pump_en", ep, c[4]);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        master = 1'b0;
        slow = 1'b0;
        page = 8'h00;
        addr = 8'h00;
        wdata = 8'h00;
        set_khz = 16'd12000;
        divs = '{dsp: 7'd2, modulator: 7'd1, oversample: 7'd3, pump: 7'd4};
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        chk_val("pll_en", 32'h1, {31'h0, pll_en});
        chk_val("coef", 32'h00200000, {4'h0, coef});
        for (int i = 0; i < 7; i++) exp_reg(ofs[i], rstv[i]);
        // Narrow fields drop upper bits; the unmapped offset stays empty
        for (int i = 0; i < 7; i++) wr_reg(ofs[i], 8'hff);
        for (int i = 0; i < 7; i++) exp_reg(ofs[i], fullv[i]);
        page = 8'h01;
        wr_reg(8'h15, 8'h05);
        exp_reg(8'h15, 8'h00);
        page = 8'h00;
        exp_reg(8'h15, 8'h3f);
        // 12 MHz, K 8.1920 gives a 98.304 MHz VCO and 48 kHz over 2048
        run_case(16'd12000, 4'h0, 6'd8, 8'h80, 4'h0, 1'b0);
        wr_reg(8'h16, 8'h07);
        settle();
        chk_val("cfg_err", 32'h0, {31'h0, cfg_err});
        chk_val("mismatch", 32'h0, {31'h0, mismatch});
        master = 1'b1;
        settle();
        chk_val("mismatch", 32'h1, {31'h0, mismatch});
        run_case(16'd12000, 4'h0, 6'd6, 8'h04, 4'h0, 1'b0);
        chk_val("coef_d", 32'h4, {18'h0, coef.d});
        run_case(16'd12000, 4'h0, 6'd8, 8'h80, 4'h1, 1'b1);
        run_case(16'd12000, 4'h0, 6'd8, 8'h00, 4'h1, 1'b1);
        chk_val("mismatch", 32'h0, {31'h0, mismatch});
        run_case(16'd12000, 4'h0, 6'd4, 8'h00, 4'h1, 1'b0);
        run_case(16'd12000, 4'h0, 6'd0, 8'h00, 4'h0, 1'b1);
        run_case(16'd12000, 4'h1, 6'd16, 8'h00, 4'h0, 1'b0);
        run_case(16'd12000, 4'h1, 6'd11, 8'h01, 4'h0, 1'b1);
        run_case(16'd8000, 4'h0, 6'd12, 8'h01, 4'h0, 1'b1);
        run_case(16'd8000, 4'h0, 6'd11, 8'h01, 4'h0, 1'b0);
        run_case(16'd20000, 4'h0, 6'd3, 8'h00, 4'h0, 1'b1);
        run_case(16'd21000, 4'h0, 6'd4, 8'h00, 4'h0, 1'b1);
        run_case(16'd16000, 4'h0, 6'd4, 8'h00, 4'h0, 1'b0);
        // A bad set with the PLL off raises nothing
        run_case(16'd12000, 4'h2, 6'd8, 8'h80, 4'h1, 1'b1);
        wr_reg(8'h04, 8'h00);
        settle();
        chk_val("pll_en", 32'h0, {31'h0, pll_en});
        chk_val("cfg_err", 32'h0, {31'h0, cfg_err});
        chk_val("mismatch", 32'h0, {31'h0, mismatch});
        // Divisors picked so the modulator ratio over the oversample one is 4
        count_en(240, 80, 80, 120, 30, 24);
        wr_reg(8'h04, 8'h01);
        count_en(240, 80, 40, 60, 15, 12);
        slow = 1'b1;
        count_en(480, 160, 40, 60, 15, 12);
        // Bypassed tree with a divide-by-one DSP divisor ticks every clock
        wr_reg(8'h04, 8'h00);
        divs.dsp = 7'd0;
        count_en(240, 80, 240, 120, 30, 24);
        report_and_stop();
    end
endmodule
